// >>> hdl/port_alt_function_mux_regs.svh
/*
 * Pin positions, function masks and reset values for the port
 * alternate-function multiplexer.
 * Assumes it is included by bare name from files under hdl/.
 */
`ifndef PORT_ALT_FUNCTION_MUX_REGS_SVH
`define PORT_ALT_FUNCTION_MUX_REGS_SVH

// =====================================================================
// Reset values
// =====================================================================
`define PAD_RST_BYTE        8'h00
`define SENSE_RST_BIT       1'b0

// =====================================================================
// Port A pin positions (timer 0, UART A, timer 1)
// =====================================================================
`define PA_TIMER0_IO        0
`define PA_TIMER0_OUT       1
`define PA_UART_DE          2
`define PA_UART_CTS         3
`define PA_UART_RX          4
`define PA_UART_TX          5
`define PA_TIMER1_IO        6
`define PA_TIMER1_OUT       7

// =====================================================================
// Port B pin positions and function masks
// =====================================================================
`define PB_CLOCK_IN         3
`define PB_DIGITAL_MASK     8'h08
`define PB_ANALOG_MASK      8'h3F

// =====================================================================
// Port C pin positions and function masks
// =====================================================================
`define PC_SPI_MISO         1
`define PC_COMP_OUT         3
`define PC_SPI_MOSI         4
`define PC_SPI_SCK          5
`define PC_TIMER2_IO        6
`define PC_TIMER2_OUT       7
`define PC_DIGITAL_MASK     8'hFA
`define PC_ANALOG_MASK      8'h07

// =====================================================================
// Port E: bonded pins and package-dependent timer pins
// =====================================================================
`define PE_PIN_MASK         8'h7F
`define PE_TIMER_MASK       8'h79

`endif

// >>> hdl/port_alt_function_mux_pkg.sv
/*
 * Types shared by the port alternate-function multiplexer.
 * Assumes nothing beyond a SystemVerilog compiler; users write
 * port_alt_function_mux_pkg::name, nothing is imported.
 */
package port_alt_function_mux_pkg;

    // =================================================================
    // Package variants
    // =================================================================
    typedef enum logic [1:0] {
        PKG_28 = 2'b00,
        PKG_40 = 2'b01,
        PKG_44 = 2'b10
    } package_t;

    // One byte per port, A to E
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
    } pad_vec_t;

    // Function-set registers exist on ports A to C only
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } select_vec_t;

    // Levels that peripherals drive towards the pads
    typedef struct packed {
        logic       timer0_compl;
        logic       timer0_compl_oe;
        logic       timer0_output;
        logic       timer1_compl;
        logic       timer1_compl_oe;
        logic       timer1_output;
        logic       timer2_compl;
        logic       timer2_compl_oe;
        logic       timer2_output;
        logic       uart_a_driver_enable;
        logic       uart_a_transmit;
        logic       comparator_a_output;
        logic       spi_miso;
        logic       spi_miso_oe;
        logic       spi_mosi;
        logic       spi_mosi_oe;
        logic       spi_sck;
        logic       spi_sck_oe;
        logic [7:0] led_level;
        logic [7:0] led_enable;
        logic [7:0] port_d_out;
        logic [7:0] port_d_oe;
        logic [7:0] port_e_out;
        logic [7:0] port_e_oe;
    } periph_drive_t;

    // Pad levels handed back to peripherals, zero when not routed
    typedef struct packed {
        logic       timer0_input;
        logic       timer1_input;
        logic       timer2_input;
        logic       uart_a_clear_to_send;
        logic       uart_a_receive;
        logic       external_clock_pin;
        logic       spi_miso;
        logic       spi_mosi;
        logic       spi_sck;
        logic [7:0] port_d_in;
        logic [7:0] port_e_in;
    } periph_sense_t;

    // Analog switch enables (ADC, comparator, amplifier, reference)
    typedef struct packed {
        logic [7:0] port_b;
        logic [7:0] port_c;
    } analog_route_t;

endpackage

// >>> hdl/port_alt_function_mux.sv
/*
 * Per-pin alternate-function multiplexer for ports A to E.
 * Chooses, per pad, between ordinary port drive and the routed
 * peripheral, and hands synchronised pad levels to peripherals.
 * Assumes: select and enable bytes come from port registers on
 * ref_clk; pad inputs are asynchronous and are synchronised here.
 */
// Notes on behaviour
// - Secondary select register kept, never steers pins
// - Alternate function needs its enable bit set
// - Ports D and E have no select registers
// - Enable alone connects D/E pin to peripheral
// - Package-dependent timer pins need largest package
// - Port C pin 0: nothing, else analog/LED
// - Port C pin 1: SPI MISO, else analog/LED
// - Port C pin 2: analog/LED on select one
// - Port C pins 3-5: comparator, MOSI, SCK, else LED
// - Port C pins 6-7: timer 2, else LED
// - Port A pins 0-1: timer 0 on select zero
// - Port A pins 2-3: UART A DE, CTS
// - Port A pins 4-5: UART A receive, transmit
// - Port A pins 6-7: timer 1 on select zero
// - Port B pins 0-2: ADC with amplifier on one
// - Port B 3 clock/ADC, 4 ADC, 5 reference
`timescale 1ns/1ns

`include "port_alt_function_mux_regs.svh"

module port_alt_function_mux (
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    input  wire port_alt_function_mux_pkg::package_t     package_sel,
    input  wire port_alt_function_mux_pkg::pad_vec_t     alt_enable,
    input  wire port_alt_function_mux_pkg::select_vec_t  function_select_reg_primary,
    input  wire port_alt_function_mux_pkg::select_vec_t  function_select_reg_secondary,
    input  wire port_alt_function_mux_pkg::pad_vec_t     gpio_out,
    input  wire port_alt_function_mux_pkg::pad_vec_t     gpio_oe,
    input  wire port_alt_function_mux_pkg::periph_drive_t periph_drive,
    input  wire port_alt_function_mux_pkg::pad_vec_t     pad_in,
    output port_alt_function_mux_pkg::pad_vec_t          pad_out,
    output port_alt_function_mux_pkg::pad_vec_t          pad_oe,
    output port_alt_function_mux_pkg::periph_sense_t     periph_sense,
    output port_alt_function_mux_pkg::analog_route_t     analog_route,
    output port_alt_function_mux_pkg::select_vec_t       secondary_readback
);

    // =================================================================
    // Pad input synchroniser
    // =================================================================
    port_alt_function_mux_pkg::pad_vec_t pad_meta_q;
    port_alt_function_mux_pkg::pad_vec_t pad_sync_q;

    // Two stages; only the second stage feeds the routing logic
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // =================================================================
    // Package decode
    // =================================================================
    logic        large_package;
    logic [7:0]  e_bonded;

    // Timer pins of port E are reserved unless the largest package
    assign large_package = (package_sel == port_alt_function_mux_pkg::PKG_44);
    assign e_bonded      = large_package ? `PE_PIN_MASK
                                         : (`PE_PIN_MASK & ~`PE_TIMER_MASK);

    // =================================================================
    // Port A: every pin has a digital function on select zero only
    // =================================================================
    logic [7:0] a_act;
    logic [7:0] a_out;
    logic [7:0] a_oe;

    // Select one is reserved here, so the pin stays with the port
    assign a_act = alt_enable.a & ~function_select_reg_primary.a;

    // Output levels of the routed peripherals, input pins drive zero
    assign a_out = {periph_drive.timer1_output,
                    periph_drive.timer1_compl,
                    periph_drive.uart_a_transmit,
                    1'b0,
                    1'b0,
                    periph_drive.uart_a_driver_enable,
                    periph_drive.timer0_output,
                    periph_drive.timer0_compl};

    // Timer I/O pins turn round under timer control
    assign a_oe  = {1'b1,
                    periph_drive.timer1_compl_oe,
                    1'b1,
                    1'b0,
                    1'b0,
                    1'b1,
                    1'b1,
                    periph_drive.timer0_compl_oe};

    // =================================================================
    // Port B: external clock on pin 3, analog set on select one
    // =================================================================
    logic [7:0] b_dig;
    logic [7:0] b_ana;
    logic [7:0] b_act;

    // Pins 0-2, 4, 5 have nothing on select zero and stay with the port
    assign b_dig = alt_enable.b & ~function_select_reg_primary.b
                   & `PB_DIGITAL_MASK;
    assign b_ana = alt_enable.b & function_select_reg_primary.b
                   & `PB_ANALOG_MASK;
    assign b_act = b_dig | b_ana;

    // =================================================================
    // Port C: digital set on select zero, analog or LED on select one
    // =================================================================
    logic [7:0] c_dig;
    logic [7:0] c_one;
    logic [7:0] c_act;
    logic [7:0] c_dig_out;
    logic [7:0] c_dig_oe;
    logic [7:0] c_out;
    logic [7:0] c_oe;

    // Pins 0 and 2 have no select-zero function
    assign c_dig = alt_enable.c & ~function_select_reg_primary.c
                   & `PC_DIGITAL_MASK;
    assign c_one = alt_enable.c & function_select_reg_primary.c;
    assign c_act = c_dig | c_one;

    assign c_dig_out = {periph_drive.timer2_output,
                        periph_drive.timer2_compl,
                        periph_drive.spi_sck,
                        periph_drive.spi_mosi,
                        periph_drive.comparator_a_output,
                        1'b0,
                        periph_drive.spi_miso,
                        1'b0};

    // SPI pins turn round by master or slave role
    assign c_dig_oe  = {1'b1,
                        periph_drive.timer2_compl_oe,
                        periph_drive.spi_sck_oe,
                        periph_drive.spi_mosi_oe,
                        1'b1,
                        1'b0,
                        periph_drive.spi_miso_oe,
                        1'b0};

    // LED drive wins over the analog switch on a shared pin
    assign c_out = (c_dig & c_dig_out) | (c_one & periph_drive.led_level);
    assign c_oe  = (c_dig & c_dig_oe)  | (c_one & periph_drive.led_enable);

    // =================================================================
    // Ports D and E: single function, enable alone connects it
    // =================================================================
    logic [7:0] d_act;
    logic [7:0] e_act;

    assign d_act = alt_enable.d;
    assign e_act = alt_enable.e & e_bonded;

    // =================================================================
    // Pad drive selection
    // =================================================================
    port_alt_function_mux_pkg::pad_vec_t pad_out_d;
    port_alt_function_mux_pkg::pad_vec_t pad_oe_d;
    port_alt_function_mux_pkg::pad_vec_t pad_out_q;
    port_alt_function_mux_pkg::pad_vec_t pad_oe_q;

    // A routed pin takes the peripheral, any other keeps the port
    assign pad_out_d.a = (a_act & a_out) | (~a_act & gpio_out.a);
    assign pad_oe_d.a  = (a_act & a_oe)  | (~a_act & gpio_oe.a);
    // Port B functions are inputs or analog: routed pins float
    assign pad_out_d.b = ~b_act & gpio_out.b;
    assign pad_oe_d.b  = ~b_act & gpio_oe.b;
    assign pad_out_d.c = (c_act & c_out) | (~c_act & gpio_out.c);
    assign pad_oe_d.c  = (c_act & c_oe)  | (~c_act & gpio_oe.c);
    assign pad_out_d.d = (d_act & periph_drive.port_d_out) | (~d_act & gpio_out.d);
    assign pad_oe_d.d  = (d_act & periph_drive.port_d_oe)  | (~d_act & gpio_oe.d);
    assign pad_out_d.e = (e_act & periph_drive.port_e_out) | (~e_act & gpio_out.e);
    assign pad_oe_d.e  = (e_act & periph_drive.port_e_oe)  | (~e_act & gpio_oe.e);

    // =================================================================
    // Pad levels back to peripherals
    // =================================================================
    port_alt_function_mux_pkg::periph_sense_t sense_d;
    port_alt_function_mux_pkg::periph_sense_t sense_q;

    // Unrouted inputs read zero so a peripheral never sees a foreign pin
    assign sense_d.timer0_input         = a_act[`PA_TIMER0_IO]  & pad_sync_q.a[`PA_TIMER0_IO];
    assign sense_d.timer1_input         = a_act[`PA_TIMER1_IO]  & pad_sync_q.a[`PA_TIMER1_IO];
    assign sense_d.uart_a_clear_to_send = a_act[`PA_UART_CTS]   & pad_sync_q.a[`PA_UART_CTS];
    // Shared by the UART and infrared receive paths
    assign sense_d.uart_a_receive       = a_act[`PA_UART_RX]    & pad_sync_q.a[`PA_UART_RX];
    assign sense_d.external_clock_pin   = b_dig[`PB_CLOCK_IN]   & pad_sync_q.b[`PB_CLOCK_IN];
    assign sense_d.timer2_input         = c_dig[`PC_TIMER2_IO]  & pad_sync_q.c[`PC_TIMER2_IO];
    assign sense_d.spi_miso             = c_dig[`PC_SPI_MISO]   & pad_sync_q.c[`PC_SPI_MISO];
    assign sense_d.spi_mosi             = c_dig[`PC_SPI_MOSI]   & pad_sync_q.c[`PC_SPI_MOSI];
    assign sense_d.spi_sck              = c_dig[`PC_SPI_SCK]    & pad_sync_q.c[`PC_SPI_SCK];
    assign sense_d.port_d_in            = d_act & pad_sync_q.d;
    assign sense_d.port_e_in            = e_act & pad_sync_q.e;

    // =================================================================
    // Analog switch enables
    // =================================================================
    port_alt_function_mux_pkg::analog_route_t analog_d;
    port_alt_function_mux_pkg::analog_route_t analog_q;

    // Port C analog pins close only while LED drive is idle
    assign analog_d.port_b = b_ana;
    assign analog_d.port_c = c_one & ~periph_drive.led_enable
                             & `PC_ANALOG_MASK;

    // =================================================================
    // Output registers
    // =================================================================
    port_alt_function_mux_pkg::select_vec_t secondary_q;

    // One cycle of latency buys glitch-free pad and peripheral levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_out_q <= {5{`PAD_RST_BYTE}};
            pad_oe_q  <= {5{`PAD_RST_BYTE}};
        end else begin
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
        end
    end

    // Routed pad levels and analog switch state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_q  <= '0;
            analog_q <= '0;
        end else begin
            sense_q  <= sense_d;
            analog_q <= analog_d;
        end
    end

    // Secondary select is held for software only, never decoded
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            secondary_q <= {3{`PAD_RST_BYTE}};
        end else begin
            secondary_q <= function_select_reg_secondary;
        end
    end

    assign pad_out            = pad_out_q;
    assign pad_oe             = pad_oe_q;
    assign periph_sense       = sense_q;
    assign analog_route       = analog_q;
    assign secondary_readback = secondary_q;

endmodule

// >>> sim/pad_world.sv
/*
 * Pad model for the alternate-function mux: resolves each pad level.
 * Assumes the bench supplies the level that outside circuits put on
 * undriven pads; the mux sees its own drive back where it drives.
 */
`timescale 1ns/1ns

module pad_world (
    input  wire port_alt_function_mux_pkg::pad_vec_t pad_out,
    input  wire port_alt_function_mux_pkg::pad_vec_t pad_oe,
    input  wire port_alt_function_mux_pkg::pad_vec_t ext_level,
    output port_alt_function_mux_pkg::pad_vec_t      pad_in
);
    // =================================================================
    // Pad resolution
    // =================================================================
    // A driven pad shows the mux level, an undriven one the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// >>> sim/port_alt_function_mux_checker.sv
/*
 * Concurrent checks on the port alternate-function mux ports.
 * Assumes single ref_clk domain; attached to the mux by bind.
 */
`timescale 1ns/1ns

module port_alt_function_mux_checker (
    input wire logic                                     ref_clk,
    input wire logic                                     rst_b,
    input wire port_alt_function_mux_pkg::package_t      package_sel,
    input wire port_alt_function_mux_pkg::pad_vec_t      alt_enable,
    input wire port_alt_function_mux_pkg::select_vec_t   function_select_reg_primary,
    input wire port_alt_function_mux_pkg::pad_vec_t      gpio_out,
    input wire port_alt_function_mux_pkg::pad_vec_t      gpio_oe,
    input wire port_alt_function_mux_pkg::periph_drive_t periph_drive,
    input wire port_alt_function_mux_pkg::pad_vec_t      pad_in,
    input wire port_alt_function_mux_pkg::pad_vec_t      pad_out,
    input wire port_alt_function_mux_pkg::pad_vec_t      pad_oe,
    input wire port_alt_function_mux_pkg::periph_sense_t periph_sense,
    input wire port_alt_function_mux_pkg::analog_route_t analog_route
);
    logic [2:0] up_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // =================================================================
    // Cycles since reset, so $past never reaches into reset values
    // =================================================================
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) up_q <= 3'h0;
        else if (up_q != 3'h4) up_q <= up_q + 3'h1;
    end
    // =================================================================
    // Properties
    // =================================================================
    property p_second_idle;
        up_q >= 3'h2 && $stable(alt_enable) && $stable(function_select_reg_primary) &&
        $stable(gpio_out) && $stable(gpio_oe) && $stable(periph_drive) &&
        $stable(package_sel) |=> $stable(pad_out) && $stable(pad_oe);
    endproperty
    property p_gate; !alt_enable.a[5] |=> pad_out.a[5] == $past(gpio_out.a[5]); endproperty
    property p_tx;
        alt_enable.a[5] && !function_select_reg_primary.a[5] |=>
            pad_out.a[5] == $past(periph_drive.uart_a_transmit) && pad_oe.a[5];
    endproperty
    property p_port_d; alt_enable.d[2] |=> pad_out.d[2] == $past(periph_drive.port_d_out[2]);
    endproperty
    property p_pkg;
        alt_enable.e[0] && package_sel != port_alt_function_mux_pkg::PKG_44 |=>
            pad_out.e[0] == $past(gpio_out.e[0]);
    endproperty
    property p_t0;
        alt_enable.a[1] && !function_select_reg_primary.a[1] |=>
            pad_out.a[1] == $past(periph_drive.timer0_output);
    endproperty
    property p_resv;
        alt_enable.a[1] && function_select_reg_primary.a[1] |=>
            pad_out.a[1] == $past(gpio_out.a[1]) && pad_oe.a[1] == $past(gpio_oe.a[1]);
    endproperty
    property p_led;
        alt_enable.c[7] && function_select_reg_primary.c[7] |=>
            pad_out.c[7] == $past(periph_drive.led_level[7]);
    endproperty
    property p_rx;
        up_q >= 3'h3 && alt_enable.a[4] && !function_select_reg_primary.a[4] |=>
            periph_sense.uart_a_receive == $past(pad_in.a[4], 3);
    endproperty
    property p_adc;
        alt_enable.b[4] && function_select_reg_primary.b[4] |=>
            analog_route.port_b[4] && !pad_oe.b[4];
    endproperty
    a_second_idle: assert property (p_second_idle) else $error("pad moved on secondary");
    a_gate: assert property (p_gate) else $error("pin rerouted without enable");
    a_tx: assert property (p_tx) else $error("transmit not on pin");
    a_port_d: assert property (p_port_d) else $error("port D not routed");
    a_pkg: assert property (p_pkg) else $error("timer pin routed in small package");
    a_t0: assert property (p_t0) else $error("timer 0 output not on pin");
    a_resv: assert property (p_resv) else $error("reserved select moved pin");
    a_led: assert property (p_led) else $error("LED drive not on pin");
    a_rx: assert property (p_rx) else $error("receive level not passed on");
    a_adc: assert property (p_adc) else $error("ADC switch not closed");
    c_tx: cover property (alt_enable.a[5] && !function_select_reg_primary.a[5]);
    c_led: cover property (alt_enable.c[7] && function_select_reg_primary.c[7]);
    c_big: cover property (alt_enable.e[0] && package_sel == port_alt_function_mux_pkg::PKG_44);
endmodule

bind port_alt_function_mux port_alt_function_mux_checker u_chk (
    .ref_clk, .rst_b, .package_sel, .alt_enable, .function_select_reg_primary, .gpio_out,
    .gpio_oe, .periph_drive, .pad_in, .pad_out, .pad_oe, .periph_sense, .analog_route);

// >>> sim/port_alt_function_mux_tb_top.sv
/*
 * Self-checking bench for the port alternate-function mux.
 * Assumes the pad model and the bound checker; one task per scenario.
 */
`timescale 1ns/1ns

module port_alt_function_mux_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    port_alt_function_mux_pkg::package_t      package_sel = port_alt_function_mux_pkg::PKG_44;
    port_alt_function_mux_pkg::pad_vec_t      alt_enable = '0, gpio_out = '0, gpio_oe = '0;
    port_alt_function_mux_pkg::pad_vec_t      ext_level = '0, pad_in, pad_out, pad_oe;
    port_alt_function_mux_pkg::select_vec_t   sel = '0, sec = '0, readback;
    port_alt_function_mux_pkg::periph_drive_t drv = '1;
    port_alt_function_mux_pkg::periph_sense_t sense;
    port_alt_function_mux_pkg::analog_route_t route;
    int fail_count = 0;
    int tests_run = 0;

    always #25 ref_clk = ~ref_clk;

    port_alt_function_mux dut (.ref_clk(ref_clk), .rst_b(rst_b), .package_sel(package_sel),
        .alt_enable(alt_enable), .function_select_reg_primary(sel),
        .function_select_reg_secondary(sec), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .periph_drive(drv), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .periph_sense(sense), .analog_route(route), .secondary_readback(readback));
    pad_world u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
        .pad_in(pad_in));

    // =================================================================
    // Shared helpers
    // =================================================================
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // =================================================================
    // Scenarios
    // =================================================================
    // Port A: select 0 routes timers and UART, select 1 falls back to gpio
    task automatic t_port_a;
        gpio_out.a = 8'h5A; gpio_oe.a = 8'hC3; step(2);
        chk("a gated out", 8'h5A, pad_out.a);
        alt_enable.a = 8'hFF; step(2);
        chk("a oe", 8'hE7, pad_oe.a);
        chk("a out", 8'hE7, pad_out.a);
        sel.a = 8'hFF; step(2);
        chk("a resv out", 8'h5A, pad_out.a);
        chk("a resv oe", 8'hC3, pad_oe.a);
        sel.a = 8'h00; ext_level.a = 8'h18; step(4);
        chk("cts rx", 8'h03, {6'h00, sense.uart_a_clear_to_send, sense.uart_a_receive});
        // Timer I/O pins see their own complement drive back through the pad
        chk("t in", 8'h03, {6'h00, sense.timer0_input, sense.timer1_input});
        sec = 24'hFF_FFFF; step(2);
        chk("a sec out", 8'hE7, pad_out.a);
        chk("sec back", 8'hFF, readback.a);
    endtask
    // Port B: analog switches on select 1, clock input on select 0
    task automatic t_port_b;
        alt_enable.b = 8'hFF; ext_level.b = 8'h08; step(4);
        chk("b clk", 8'h01, {7'h00, sense.external_clock_pin});
        chk("b analog off", 8'h00, route.port_b);
        sel.b = 8'h3F; step(2);
        chk("b analog", 8'h3F, route.port_b);
        chk("b oe", 8'h00, pad_oe.b);
    endtask
    // Port C: digital set on select 0, LED or analog on select 1
    task automatic t_port_c;
        alt_enable.c = 8'hFF; step(2);
        chk("c digital", 8'hFA, pad_out.c);
        drv.led_level = 8'h5A; sel.c = 8'hFF; step(2);
        chk("c led", 8'h5A, pad_out.c);
        chk("c led oe", 8'hFF, pad_oe.c);
        chk("c sense off", 8'h00, {4'h0, sense.timer2_input, sense.spi_miso,
            sense.spi_mosi, sense.spi_sck});
        drv.led_enable = 8'h00; step(2);
        chk("c analog", 8'h07, route.port_c);
    endtask
    // Ports D and E: enable alone connects, E timers need the big package
    task automatic t_port_de;
        drv.port_d_out = 8'h3C; drv.port_e_out = 8'hFF; gpio_out.e = 8'h00;
        alt_enable.d = 8'hFF; alt_enable.e = 8'hFF; step(2);
        chk("d out", 8'h3C, pad_out.d);
        chk("e big", 8'h7F, pad_out.e);
        package_sel = port_alt_function_mux_pkg::PKG_40; step(2);
        chk("e small", 8'h06, pad_out.e);
        // The smallest package must treat the timer pins as reserved too
        package_sel = port_alt_function_mux_pkg::PKG_28;
        step(2);
        chk("e 28", 8'h06, pad_out.e);
        ext_level.d = 8'h81; drv.port_d_oe = 8'h00; step(4);
        chk("d in", 8'h81, sense.port_d_in);
        chk("e in", 8'h06, sense.port_e_in);
    endtask
    // Mid-run reset clears every output, release picks up the inputs again
    task automatic t_reset;
        rst_b = 1'b0;
        step(1);
        chk("rst d out", 8'h00, pad_out.d);
        chk("rst sec", 8'h00, readback.a);
        rst_b = 1'b1;
        step(1);
        chk("rel d out", 8'h3C, pad_out.d);
        chk("rel sec", 8'hFF, readback.a);
    endtask

    // =================================================================
    // Main sequence and watchdog
    // =================================================================
    initial begin
        step(3);
        rst_b = 1'b1;
        step(1);
        t_port_a;
        t_port_b;
        t_port_c;
        t_port_de;
        t_reset;
        complete_run;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        complete_run;
    end
endmodule
